// >>> rtl/lcd_timing_pkg.sv
package lcd_timing_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] CONTROL_OFFSET = 8'h00;
	localparam logic [7:0] TIMING_OFFSET = 8'h04;
	localparam logic [7:0] STATUS_OFFSET = 8'h08;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_ACTIVE_BIT = 1;
	localparam int CTRL_ALT_MAP_BIT = 2;
	localparam int CTRL_565_BIT = 3;
	localparam int CTRL_WIDE_BIT = 4;
	localparam logic [31:0] CONTROL_RESET = 32'h00000000;

	// ----------------------------------------------------------------
	// Horizontal timing register fields
	// ----------------------------------------------------------------
	localparam int BACK_PORCH_LSB = 24;
	localparam int FRONT_PORCH_LSB = 16;
	localparam int SYNC_WIDTH_LSB = 10;
	localparam int ROW_LSB = 0;
	localparam int ROW_USED_LSB = 4;
	localparam logic [3:0] ROW_LOW_ONES = 4'hF;
	localparam logic [31:0] TIMING_RESET = 32'h0000000F;

	// ----------------------------------------------------------------
	// Status register fields
	// ----------------------------------------------------------------
	localparam int STAT_PHASE_LSB = 0;
	localparam int STAT_LINE_CLOCK_BIT = 8;
	localparam int STAT_PIXEL_CLOCK_BIT = 9;
	localparam int STAT_COUNT_LSB = 16;

	// ----------------------------------------------------------------
	// Line phases
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		PHASE_IDLE = 5'b00001,
		PHASE_ACTIVE = 5'b00010,
		PHASE_FRONT = 5'b00100,
		PHASE_SYNC = 5'b01000,
		PHASE_BACK = 5'b10000
	} phase_t;

endpackage

// >>> rtl/edge_sync.sv
`timescale 1ns/1ps
module edge_sync
	import lcd_timing_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic async_in,
	output logic level,
	output logic rise
);

	typedef struct packed {
		logic stage1;
		logic stage2;
		logic stage3;
	} sync_state_t;

	sync_state_t s;
	sync_state_t next_s;

	// Stage1 feeds stage2 only; edges are found on the settled stages
	always_comb begin
		next_s = s;
		next_s.stage1 = async_in;
		next_s.stage2 = s.stage1;
		next_s.stage3 = s.stage2;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign level = s.stage2;
	assign rise = s.stage2 & ~s.stage3;

endmodule

// >>> rtl/pixel_mapper.sv
`timescale 1ns/1ps
module pixel_mapper
	import lcd_timing_pkg::*;
(
	input wire logic [11:0] rgb,
	input wire logic alternate_pin_mapping,
	output logic [15:0] pins
);

	logic [3:0] red;
	logic [3:0] green;
	logic [3:0] blue;

	assign red = rgb[11:8];
	assign green = rgb[7:4];
	assign blue = rgb[3:0];

	always_comb begin
		if (alternate_pin_mapping) begin
			// Duplicated MSBs let a panel wired for 16 lines see full swing
			pins = {red, red[3], green, green[3], green[2], blue, blue[3]};
		end else begin
			pins = {4'h0, red, green, blue};
		end
	end

endmodule

// >>> rtl/lcd_horizontal_timing.sv
`timescale 1ns/1ps
// How it works
// - Alternate pin mapping only acts in active display mode, ignored when passive.
// - Alternate mapping: R on 15..12, R3 on 11, G 10..7, G3, G2, B 4..1, B3.
// - Normal mapping: twelve colour bits right-aligned on 11..0, upper four pins zero.
// - 5-6-5 layout only counts in passive mode with 12/16-bit pixels.
// - Without 5-6-5: red word 11..8, green 7..4, blue 3..0, top ignored.
// - With 5-6-5: red word 15..11, green 10..5, blue 4..0.
// - 5-6-5 sends twelve bits to dither, dropping bits 11, 6, 5 and 0.
// - Pixels-per-row is width minus one, multiple of 16; low four bits read ones.
// - Programmed count of active pixel clocks runs before the line clock may pulse.
// - 6-bit sync width loads the 10-bit down counter; pulse ends at zero, 1 to 64 clocks.
// - Front porch waits field plus one pixel clocks after the row.
// - Back porch waits field plus one pixel clocks after line clock negates.
// - Passive mode stops pixel clock in blanking; active mode keeps it toggling.
// - Timing register: back porch 31:24, front 23:16, sync 15:10, row 9:0.
// - Display-type bit zero selects passive mode, one selects active mode.
module lcd_horizontal_timing
	import lcd_timing_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pixel_clock_source,
	input wire logic [15:0] pixel_word,
	input wire logic [11:0] dithered_pixel,
	output logic pixel_take,
	output logic [11:0] dither_word,
	output logic dither_valid,
	output logic pixel_clock,
	output logic line_clock,
	output logic [15:0] pixel_data
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic ctrl_enable;
		logic active_display_select;
		logic alternate_pin_mapping;
		logic passive_five_six_five_layout;
		logic wide_pixels;
		logic [7:0] line_back_porch;
		logic [7:0] line_front_porch;
		logic [5:0] line_sync_width;
		logic [5:0] row_upper;
		phase_t phase;
		logic [9:0] count;
		logic pixel_clock;
		logic line_clock;
		logic pixel_take;
		logic dither_valid;
		logic [15:0] pixel_data;
		logic [11:0] dither_word;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} block_state_t;

	block_state_t s;
	block_state_t next_s;

	logic source_level;
	logic source_rise;
	logic [15:0] mapped_pins;
	logic [11:0] pin_colour;
	logic [9:0] pixels_per_row;
	logic [31:0] control_view;
	logic [31:0] timing_view;
	logic [31:0] status_view;
	logic map_select;
	logic setup_phase;
	logic access_phase;
	logic write_accept;
	logic control_write;
	logic timing_write;
	logic [31:0] read_view;
	logic read_refused;
	logic [9:0] load_value;
	logic [11:0] dither_source;

	// ----------------------------------------------------------------
	// Pixel clock source crossing
	// ----------------------------------------------------------------
	edge_sync source_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(pixel_clock_source),
		.level(source_level),
		.rise(source_rise)
	);

	// ----------------------------------------------------------------
	// Output pin mapping
	// ----------------------------------------------------------------
	// Passive data comes back from the dither stage; active data skips it
	assign pin_colour = s.active_display_select ? pixel_word[11:0] : dithered_pixel;
	assign map_select = s.alternate_pin_mapping & s.active_display_select;

	pixel_mapper pin_map (
		.rgb(pin_colour),
		.alternate_pin_mapping(map_select),
		.pins(mapped_pins)
	);

	// ----------------------------------------------------------------
	// Register views
	// ----------------------------------------------------------------
	// Low four bits are not stored; narrower widths than 16 are unsupported
	assign pixels_per_row = {s.row_upper, ROW_LOW_ONES};

	always_comb begin
		control_view = '0;
		control_view[CTRL_ENABLE_BIT] = s.ctrl_enable;
		control_view[CTRL_ACTIVE_BIT] = s.active_display_select;
		control_view[CTRL_ALT_MAP_BIT] = s.alternate_pin_mapping;
		control_view[CTRL_565_BIT] = s.passive_five_six_five_layout;
		control_view[CTRL_WIDE_BIT] = s.wide_pixels;
	end

	always_comb begin
		timing_view = '0;
		timing_view[BACK_PORCH_LSB +: 8] = s.line_back_porch;
		timing_view[FRONT_PORCH_LSB +: 8] = s.line_front_porch;
		timing_view[SYNC_WIDTH_LSB +: 6] = s.line_sync_width;
		timing_view[ROW_LSB +: 10] = pixels_per_row;
	end

	always_comb begin
		status_view = '0;
		status_view[STAT_PHASE_LSB +: 5] = s.phase;
		status_view[STAT_LINE_CLOCK_BIT] = s.line_clock;
		status_view[STAT_PIXEL_CLOCK_BIT] = s.pixel_clock;
		status_view[STAT_COUNT_LSB +: 10] = s.count;
	end

	// ----------------------------------------------------------------
	// Register write strobes
	// ----------------------------------------------------------------
	assign setup_phase = psel & ~penable;
	assign access_phase = psel & penable & s.pready;
	// Refusal was latched in setup, so a refused write never lands
	assign write_accept = access_phase & pwrite & ~s.pslverr;
	assign control_write = write_accept & (paddr == CONTROL_OFFSET);
	assign timing_write = write_accept & (paddr == TIMING_OFFSET);

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	// Refused accesses answer with zero so no stale word leaks out
	always_comb begin
		read_view = '0;
		read_refused = 1'b0;
		case (paddr)
			CONTROL_OFFSET: begin
				read_view = control_view;
			end
			TIMING_OFFSET: begin
				read_view = timing_view;
			end
			STATUS_OFFSET: begin
				// Status is read-only; a write is refused and changes nothing
				read_refused = pwrite;
				if (!pwrite) begin
					read_view = status_view;
				end
			end
			default: begin
				read_refused = 1'b1;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Phase lengths and pixel split
	// ----------------------------------------------------------------
	// Counter reload value for the phase that is about to start
	always_comb begin
		case (s.phase)
			PHASE_ACTIVE: begin
				load_value = {2'b00, s.line_front_porch};
			end
			PHASE_FRONT: begin
				load_value = {4'h0, s.line_sync_width};
			end
			PHASE_SYNC: begin
				load_value = {2'b00, s.line_back_porch};
			end
			PHASE_BACK: begin
				load_value = pixels_per_row;
			end
			default: begin
				load_value = pixels_per_row;
			end
		endcase
	end

	// 5-6-5 only in passive mode at 12/16-bit pixels
	always_comb begin
		if (s.passive_five_six_five_layout && s.wide_pixels) begin
			// Drop the red, green and blue LSBs to fit the dither
			dither_source = {pixel_word[15:12], pixel_word[10:7],
				pixel_word[4:1]};
		end else begin
			dither_source = pixel_word[11:0];
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.pixel_take = 1'b0;
		next_s.dither_valid = 1'b0;

		// APB: answer is prepared in the setup cycle so pready is a flop
		next_s.pready = setup_phase;
		// Error flag stands only for the access cycle
		next_s.pslverr = 1'b0;
		if (setup_phase) begin
			next_s.prdata = read_view;
			next_s.pslverr = read_refused;
		end

		// Timing fields take effect at the next counter load; control fields act at once, even mid-phase
		if (control_write) begin
			next_s.ctrl_enable = pwdata[CTRL_ENABLE_BIT];
			next_s.active_display_select = pwdata[CTRL_ACTIVE_BIT];
			next_s.alternate_pin_mapping = pwdata[CTRL_ALT_MAP_BIT];
			next_s.passive_five_six_five_layout = pwdata[CTRL_565_BIT];
			next_s.wide_pixels = pwdata[CTRL_WIDE_BIT];
		end
		if (timing_write) begin
			next_s.line_back_porch = pwdata[BACK_PORCH_LSB +: 8];
			next_s.line_front_porch = pwdata[FRONT_PORCH_LSB +: 8];
			next_s.line_sync_width = pwdata[SYNC_WIDTH_LSB +: 6];
			next_s.row_upper = pwdata[ROW_USED_LSB +: 6];
		end

		// Line sequencer: counters load value and run down through zero,
		// so each phase lasts field plus one pixel clocks
		if (!s.ctrl_enable) begin
			next_s.phase = PHASE_IDLE;
			next_s.count = '0;
			next_s.line_clock = 1'b0;
		end else begin
			case (s.phase)
				PHASE_IDLE: begin
					next_s.phase = PHASE_ACTIVE;
					next_s.count = pixels_per_row;
				end
				PHASE_ACTIVE: begin
					if (source_rise) begin
						next_s.pixel_take = 1'b1;
						next_s.pixel_data = mapped_pins;
						if (!s.active_display_select) begin
							next_s.dither_valid = 1'b1;
							next_s.dither_word = dither_source;
						end
						if (s.count == '0) begin
							next_s.phase = PHASE_FRONT;
							next_s.count = load_value;
						end else begin
							next_s.count = s.count - 10'd1;
						end
					end
				end
				PHASE_FRONT: begin
					if (source_rise) begin
						if (s.count == '0) begin
							next_s.phase = PHASE_SYNC;
							next_s.count = load_value;
							next_s.line_clock = 1'b1;
						end else begin
							next_s.count = s.count - 10'd1;
						end
					end
				end
				PHASE_SYNC: begin
					if (source_rise) begin
						if (s.count == '0) begin
							next_s.phase = PHASE_BACK;
							next_s.line_clock = 1'b0;
							next_s.count = load_value;
						end else begin
							next_s.count = s.count - 10'd1;
						end
					end
				end
				PHASE_BACK: begin
					if (source_rise) begin
						if (s.count == '0) begin
							next_s.phase = PHASE_ACTIVE;
							next_s.count = pixels_per_row;
						end else begin
							next_s.count = s.count - 10'd1;
						end
					end
				end
				default: begin
					next_s.phase = PHASE_IDLE;
					next_s.line_clock = 1'b0;
				end
			endcase
		end

		// Passive panels see no pixel clock edges in blanking; gating on the
		// new phase may clip the last high half, which the panel ignores
		if (s.ctrl_enable && (s.active_display_select || next_s.phase == PHASE_ACTIVE)) begin
			next_s.pixel_clock = source_level;
		end else begin
			next_s.pixel_clock = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.phase <= PHASE_IDLE;
			s.ctrl_enable <= CONTROL_RESET[CTRL_ENABLE_BIT];
			s.row_upper <= TIMING_RESET[ROW_USED_LSB +: 6];
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign pixel_take = s.pixel_take;
	assign dither_word = s.dither_word;
	assign dither_valid = s.dither_valid;
	assign pixel_clock = s.pixel_clock;
	assign line_clock = s.line_clock;
	assign pixel_data = s.pixel_data;

endmodule

// >>> bench/lcd_horizontal_timing_checker.sv
`timescale 1ns/1ps
module lcd_horizontal_timing_checker
	import lcd_timing_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic pixel_take,
	input wire logic dither_valid,
	input wire logic line_clock
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence access_s;
		psel && penable && pready;
	endsequence
	apb_answer_a: assert property (setup_s |=> pready)
		else $error("no answer after setup");
	apb_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	unmapped_err_a: assert property (access_s ##0 (paddr > 8'h08) |-> pslverr)
		else $error("unmapped access not refused");
	err_data_a: assert property (pslverr |-> prdata == 32'h00000000)
		else $error("refused access returned data");
	row_ones_a: assert property (
		access_s ##0 (!pwrite && paddr == TIMING_OFFSET) |-> prdata[3:0] == ROW_LOW_ONES)
		else $error("row field low bits not ones");
	take_gap_a: assert property (pixel_take |=> !pixel_take [*8])
		else $error("pixel takes closer than one tick");
	sync_min_a: assert property ($rose(line_clock) |-> line_clock [*8])
		else $error("line clock shorter than one tick");
	sync_quiet_a: assert property (line_clock |-> !pixel_take && !dither_valid)
		else $error("pixel moved during line sync");
endmodule
bind lcd_horizontal_timing lcd_horizontal_timing_checker u_chk (.*);

// >>> bench/lcd_panel_model.sv
`timescale 1ns/1ps
module lcd_panel_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pixel_clock,
	input wire logic line_clock,
	input wire logic pixel_take,
	input wire logic dither_valid,
	input wire logic [11:0] dither_word,
	output int lines,
	output int total,
	output int takes,
	output int hi_cycles,
	output logic [11:0] dw
);
	int t_cnt;
	int k_cnt;
	int h_cnt;
	logic pc_q;
	logic lc_q;
	// A line is measured from one line clock fall to the next
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lines <= 0;
			dw <= 12'h000;
			pc_q <= 1'h0;
			lc_q <= 1'h0;
		end else begin
			pc_q <= pixel_clock;
			lc_q <= line_clock;
			if (pixel_clock && !pc_q) t_cnt <= t_cnt + 1;
			if (pixel_take) k_cnt <= k_cnt + 1;
			if (line_clock) h_cnt <= h_cnt + 1;
			if (dither_valid) dw <= dither_word;
			if (lc_q && !line_clock) begin
				total <= t_cnt;
				takes <= k_cnt;
				hi_cycles <= h_cnt;
				lines <= lines + 1;
				t_cnt <= int'(pixel_clock && !pc_q);
				k_cnt <= int'(pixel_take);
				h_cnt <= 0;
			end
		end
	end
endmodule

// >>> bench/lcd_horizontal_timing_tb.sv
`timescale 1ns/1ps
module lcd_horizontal_timing_tb;
	import lcd_timing_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic pixel_clock_source = 0, er;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, pixel_take, dither_valid, pixel_clock, line_clock;
	logic [15:0] pixel_word = 16'hFA5C, pixel_data;
	logic [11:0] dithered_pixel = 12'h3C6, dither_word, dw;
	int num_errors = 0, n_checks = 0, cycles = 0, lines, total, takes, hi_cycles;
	lcd_horizontal_timing u_dut (.*);
	lcd_panel_model u_panel (.*);
	always #5 pclk = ~pclk;
	// Pixel source is free running and unrelated to pclk
	always #62.5 pixel_clock_source = ~pixel_clock_source;
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors = num_errors + 1;
			end_sim();
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_rng(input int got, input int lo, input int hi);
		n_checks++;
		if (got < lo || got > hi) begin
			num_errors++;
			$display("[ERR] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// Three lines let a mode change settle before the last one is judged
	task automatic run_line(input logic [31:0] ctrl, input int lo, input int hi,
		input logic [15:0] pins, input logic [11:0] dwe);
		int l0;
		apb(1'h1, CONTROL_OFFSET, ctrl);
		l0 = lines;
		wait (lines >= l0 + 3);
		check_rng(total, lo, hi);
		check_rng(takes, 16, 16);
		check_rng(hi_cycles, 48, 52);
		check(pixel_data, pins);
		check(dw, dwe);
	endtask
	task automatic t_regs;
		apb(1'h0, TIMING_OFFSET, 32'h0);
		check(rd, 32'h0000000F);
		apb(1'h0, CONTROL_OFFSET, 32'h0);
		check(rd, 32'h00000000);
		apb(1'h0, STATUS_OFFSET, 32'h0);
		check(rd, 32'h00000001);
		apb(1'h1, TIMING_OFFSET, 32'h02010C00);
		apb(1'h0, TIMING_OFFSET, 32'h0);
		check(rd, 32'h02010C0F);
		apb(1'h0, 8'h0C, 32'h0);
		check(er, 32'h1);
		check(rd, 32'h0);
		apb(1'h1, STATUS_OFFSET, 32'hFFFFFFFF);
		check(er, 32'h1);
	endtask
	// Line is 3 back + 16 pixels + 2 front + 4 sync ticks
	task automatic t_active;
		run_line(32'h13, 25, 25, 16'h0A5C, 12'h000);
	endtask
	task automatic t_alt;
		run_line(32'h17, 25, 25, 16'hAAB9, 12'h000);
	endtask
	// Passive gating may clip the edge pixel clock, hence the slack
	task automatic t_passive_alt;
		run_line(32'h15, 15, 17, 16'h03C6, 12'hA5C);
	endtask
	task automatic t_565;
		run_line(32'h1D, 15, 17, 16'h03C6, 12'hF4E);
	endtask
	task automatic t_565_narrow;
		run_line(32'h0D, 15, 17, 16'h03C6, 12'hA5C);
	endtask
	task automatic end_sim;
		$display("errors %0d checks %0d", num_errors, n_checks);
		if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		t_regs();
		t_active();
		t_alt();
		t_passive_alt();
		t_565();
		t_565_narrow();
		end_sim();
	end
endmodule
